// ===== rtl/pic_pkg.sv
// Package for the eight-level priority interrupt core: command word fields,
// vector constants, state encodings and the synchroniser bundle.
// Assumes one 200 MHz system clock; every host pin is sampled through it.
package pic_pkg;

  localparam int NUM_LEVELS = 8;
  localparam int SYNC_W = 12;
  localparam logic [11:0] SYNC_IDLE = 12'h00F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CALL_OPCODE = 8'hCD;
  localparam logic [2:0] DEFAULT_LEVEL = 3'h7;
  localparam logic [2:0] CASCADE_IDLE = 3'h0;
  localparam logic [7:0] EDGE_ARM = 8'hFF;

  // First initialization word
  localparam int ICW1_IC4 = 0;
  localparam int ICW1_SNGL = 1;
  localparam int ICW1_ADI = 2;
  localparam int ICW1_LTIM = 3;
  localparam int ICW1_INIT = 4;
  // Fourth initialization word
  localparam int ICW4_UPM = 0;
  localparam int ICW4_AUTO_END_OF_IRQ = 1;
  // Operation words written with port select low
  localparam int OCW_SEL = 3;
  localparam int OCW2_EOI = 5;
  localparam int OCW2_SPECIFIC = 6;
  localparam int OCW3_RIS = 0;
  localparam int OCW3_RR = 1;
  localparam int OCW3_POLL = 2;

  typedef enum logic [4:0] {
    INIT_WAIT_ICW1 = 5'h01,
    INIT_WAIT_ICW2 = 5'h02,
    INIT_WAIT_ICW3 = 5'h04,
    INIT_WAIT_ICW4 = 5'h08,
    INIT_READY = 5'h10
  } init_state_t;

  typedef enum logic [2:0] {
    ACK_PULSE1 = 3'h1,
    ACK_PULSE2 = 3'h2,
    ACK_PULSE3 = 3'h4
  } ack_state_t;

  typedef struct packed {
    logic [7:0] req;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic ack_n;
  } sync_bundle_t;

  // Bit 3 is the valid flag, bits 2:0 the level; level 0 wins
  function automatic logic [3:0] highest(input logic [7:0] v);
    highest = 4'h0;
    for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        highest = {1'b1, 3'(i)};
      end
    end
  endfunction

endpackage

// ===== rtl/pic_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes the inputs are quasi-static levels; no data word is passed here.
`timescale 1ns/1ps
`default_nettype none
module pic_sync #(
  parameter int WIDTH = 12,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/pic_resolver.sv
// Fixed-priority resolver: picks the best unmasked request and the best
// level in service, and says whether the request may interrupt.
// Assumes the mask has already been applied to the pending bits.
`timescale 1ns/1ps
`default_nettype none
module pic_resolver
  import pic_pkg::*;
(
  input wire logic [7:0] pending_i,
  input wire logic [7:0] in_service_i,
  output logic req_valid_o,
  output logic [2:0] req_level_o,
  output logic isr_valid_o,
  output logic [2:0] isr_level_o,
  output logic raise_o
);

  logic [3:0] req_best;
  logic [3:0] isr_best;

  always_comb begin
    req_best = highest(pending_i);
    isr_best = highest(in_service_i);
    req_valid_o = req_best[3];
    req_level_o = req_best[2:0];
    isr_valid_o = isr_best[3];
    isr_level_o = isr_best[2:0];
    // Lower level number means higher priority
    raise_o = req_best[3] && (!isr_best[3] || (req_best[2:0] < isr_best[2:0]));
  end

endmodule
`default_nettype wire

// ===== rtl/priority_interrupt_core.sv
// Eight-level priority interrupt core with host port, acknowledge vectoring
// and three-line cascade. Assumes host holds data and port select stable
// for the whole strobe, and strobes last at least three clock cycles.
//
// Notes on behaviour
// - Keep pending and in-service bits per level.
// - High request input sets its pending bit.
// - Acknowledge moves best pending bit into service.
// - Mask gates pending bits, per level only.
// - Interrupt only when winner beats in-service level.
// - Reads and writes need chip select; acknowledge not.
// - Selected write strobe loads addressed command word.
// - Selected read returns pending, service, mask or poll.
// - Port select picks written and read register.
// - Eight-bit data port driven only for reads, vectors.
// - Cascade lines output as master, input as slave.
// - Master names slave; slave supplies vector bytes.
// - Call mode pulse one, not as slave: grant, send call opcode.
// - Call mode: low address, then high address byte.
// - Call mode auto end clears service after pulse three.
// - Otherwise service bit waits for end command.
// - Pointer mode: data bus idle on pulse one.
// - Pointer mode pulse two: grant, send pointer byte.
// - Pointer mode auto end clears after pulse two.
// - No request left means answer as level seven.
// - Default level seven: cascade idle, master vectors.
// - Edge mode needs rise and hold; level mode level.
// - Pointer byte: five programmed bits, three level bits.
// - Port select low, bit four high starts initialization.
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_core
  import pic_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] request_in_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic port_select_i,
  input wire logic irq_ack_n_i,
  input wire logic slave_prog_buf_enable_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input wire logic [2:0] cascade_id_i,
  output logic [2:0] cascade_id_o,
  output logic cascade_id_oe_o,
  output logic irq_o
);

  sync_bundle_t raw;
  sync_bundle_t syn;
  sync_bundle_t prev_q;
  logic [SYNC_W-1:0] syn_bits;

  init_state_t init_q;
  ack_state_t ack_q;
  logic [7:0] icw1_q, icw2_q, icw3_q, icw4_q;
  logic [7:0] pending_request_reg;
  logic [7:0] in_service_reg;
  logic [7:0] level_mask_reg;
  logic [7:0] req_prev_q;
  logic master_q, read_isr_q, poll_q;
  logic [2:0] seq_level_q;
  logic seq_real_q, via_slave_q, owner_q, granted_q;

  logic res_req_valid, res_isr_valid, res_raise;
  logic [2:0] res_req_level, res_isr_level;
  logic wr_start, rd_start, rd_end, ack_fall, ack_rise;
  logic is_icw1, is_icw2, is_icw3, is_icw4, is_ocw1, is_ocw2, is_ocw3;
  logic first, second, third, final_rise;
  logic single, ptr_mode, auto_eoi, slave_here, cas_match, via_slave, owner;
  logic [2:0] live_level, grant_level;
  logic grant, poll_grant;
  logic [7:0] grant_mask, eoi_mask, status, vec_low, ptr_vec;

  assign raw = '{req: request_in_i, cs_n: cs_n_i, rd_n: rd_n_i, wr_n: wr_n_i,
                 ack_n: irq_ack_n_i};
  assign syn = sync_bundle_t'(syn_bits);

  pic_sync #(.WIDTH(SYNC_W), .RST_VAL(SYNC_IDLE)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(raw),
    .sync_o(syn_bits)
  );

  pic_resolver u_resolver (
    .pending_i(pending_request_reg & ~level_mask_reg),
    .in_service_i(in_service_reg),
    .req_valid_o(res_req_valid),
    .req_level_o(res_req_level),
    .isr_valid_o(res_isr_valid),
    .isr_level_o(res_isr_level),
    .raise_o(res_raise)
  );

  // Strobe edges and command decode
  always_comb begin
    wr_start = prev_q.wr_n && !syn.wr_n && !syn.cs_n;
    rd_start = prev_q.rd_n && !syn.rd_n && !syn.cs_n;
    rd_end = !prev_q.rd_n && syn.rd_n;
    ack_fall = prev_q.ack_n && !syn.ack_n;
    ack_rise = !prev_q.ack_n && syn.ack_n;
    is_icw1 = wr_start && !port_select_i && data_i[ICW1_INIT];
    is_icw2 = wr_start && port_select_i && (init_q == INIT_WAIT_ICW2);
    is_icw3 = wr_start && port_select_i && (init_q == INIT_WAIT_ICW3);
    is_icw4 = wr_start && port_select_i && (init_q == INIT_WAIT_ICW4);
    is_ocw1 = wr_start && port_select_i && (init_q == INIT_READY);
    is_ocw2 = wr_start && !port_select_i && !data_i[ICW1_INIT] && !data_i[OCW_SEL];
    is_ocw3 = wr_start && !port_select_i && !data_i[ICW1_INIT] && data_i[OCW_SEL];
  end

  // Acknowledge sequence decode
  always_comb begin
    single = icw1_q[ICW1_SNGL];
    ptr_mode = icw4_q[ICW4_UPM];
    auto_eoi = icw4_q[ICW4_AUTO_END_OF_IRQ];
    slave_here = !single && !master_q;
    cas_match = (cascade_id_i == icw3_q[2:0]);
    first = ack_fall && (ack_q == ACK_PULSE1);
    second = ack_fall && (ack_q == ACK_PULSE2);
    third = ack_fall && (ack_q == ACK_PULSE3);
    final_rise = ack_rise && ((ptr_mode && (ack_q == ACK_PULSE2)) || (ack_q == ACK_PULSE3));
    live_level = res_req_valid ? res_req_level : DEFAULT_LEVEL;
    // Default level never routes to a slave
    via_slave = !single && master_q && res_req_valid && icw3_q[live_level];
    owner = slave_here ? cas_match : !via_slave_q;
    poll_grant = rd_start && poll_q && res_req_valid;
    grant_level = (first || poll_grant) ? live_level : seq_level_q;
    grant = poll_grant
         || (first && res_req_valid && !ptr_mode && !slave_here)
         || (second && seq_real_q && ptr_mode && !slave_here)
         || (second && seq_real_q && slave_here && owner);
    grant_mask = grant ? (8'h01 << grant_level) : REG_RESET;
    eoi_mask = REG_RESET;
    if (is_ocw2 && data_i[OCW2_EOI]) begin
      if (data_i[OCW2_SPECIFIC]) begin
        eoi_mask = 8'h01 << data_i[2:0];
      end else if (res_isr_valid) begin
        eoi_mask = 8'h01 << res_isr_level;
      end
    end
    if (final_rise && auto_eoi && granted_q) begin
      eoi_mask = eoi_mask | (8'h01 << seq_level_q);
    end
    vec_low = icw1_q[ICW1_ADI] ? {icw1_q[7:5], seq_level_q, 2'b00}
                               : {icw1_q[7:6], seq_level_q, 3'b000};
    ptr_vec = {icw2_q[7:3], seq_level_q};
    if (poll_q) begin
      status = {res_req_valid, 4'h0, res_req_level};
    end else if (port_select_i) begin
      status = level_mask_reg;
    end else if (read_isr_q) begin
      status = in_service_reg;
    end else begin
      status = pending_request_reg;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      prev_q <= sync_bundle_t'(SYNC_IDLE);
      master_q <= 1'b1;
    end else begin
      prev_q <= syn;
      master_q <= slave_prog_buf_enable_i;
    end
  end

  // Initialization sequence and command words
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      init_q <= INIT_WAIT_ICW1;
      icw1_q <= REG_RESET;
      icw2_q <= REG_RESET;
      icw3_q <= REG_RESET;
      icw4_q <= REG_RESET;
      read_isr_q <= 1'b0;
      poll_q <= 1'b0;
    end else if (is_icw1) begin
      init_q <= INIT_WAIT_ICW2;
      icw1_q <= data_i;
      icw4_q <= REG_RESET;
      read_isr_q <= 1'b0;
      poll_q <= 1'b0;
    end else begin
      if (is_icw2) begin
        icw2_q <= data_i;
        if (!icw1_q[ICW1_SNGL]) begin
          init_q <= INIT_WAIT_ICW3;
        end else if (icw1_q[ICW1_IC4]) begin
          init_q <= INIT_WAIT_ICW4;
        end else begin
          init_q <= INIT_READY;
        end
      end else if (is_icw3) begin
        icw3_q <= data_i;
        init_q <= icw1_q[ICW1_IC4] ? INIT_WAIT_ICW4 : INIT_READY;
      end else if (is_icw4) begin
        icw4_q <= data_i;
        init_q <= INIT_READY;
      end
      if (is_ocw3) begin
        if (data_i[OCW3_RR]) begin
          read_isr_q <= data_i[OCW3_RIS];
        end
        poll_q <= data_i[OCW3_POLL];
      end else if (rd_start && poll_q) begin
        poll_q <= 1'b0;
      end
    end
  end

  // Mask register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      level_mask_reg <= REG_RESET;
    end else if (is_icw1) begin
      level_mask_reg <= REG_RESET;
    end else if (is_ocw1) begin
      level_mask_reg <= data_i;
    end
  end

  // Pending requests; a fresh edge wins over a grant clear
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pending_request_reg <= REG_RESET;
      req_prev_q <= REG_RESET;
    end else if (is_icw1) begin
      pending_request_reg <= REG_RESET;
      req_prev_q <= EDGE_ARM; // Held-high inputs must drop and rise again
    end else begin
      req_prev_q <= syn.req;
      if (icw1_q[ICW1_LTIM]) begin
        pending_request_reg <= syn.req;
      end else begin
        pending_request_reg <= (pending_request_reg & syn.req & ~grant_mask)
                             | (syn.req & ~req_prev_q);
      end
    end
  end

  // In-service bits; a grant wins over an end-of-interrupt in the same cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      in_service_reg <= REG_RESET;
    end else if (is_icw1) begin
      in_service_reg <= REG_RESET;
    end else begin
      in_service_reg <= (in_service_reg & ~eoi_mask) | grant_mask;
    end
  end

  // Acknowledge pulse tracking
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= ACK_PULSE1;
      seq_level_q <= DEFAULT_LEVEL;
      seq_real_q <= 1'b0;
      via_slave_q <= 1'b0;
      owner_q <= 1'b0;
      granted_q <= 1'b0;
    end else if (is_icw1) begin
      ack_q <= ACK_PULSE1;
      granted_q <= 1'b0;
    end else begin
      if (first) begin
        seq_level_q <= live_level; // Frozen for the rest of the sequence
        seq_real_q <= res_req_valid;
        via_slave_q <= via_slave;
        owner_q <= !slave_here && !via_slave;
        granted_q <= grant;
      end else if (second) begin
        owner_q <= owner;
        granted_q <= granted_q || grant;
      end
      if (final_rise) begin
        ack_q <= ACK_PULSE1;
      end else if (ack_rise && (ack_q == ACK_PULSE1)) begin
        ack_q <= ACK_PULSE2;
      end else if (ack_rise && (ack_q == ACK_PULSE2)) begin
        ack_q <= ACK_PULSE3;
      end
    end
  end

  // Data port: driven only for status reads and vector bytes
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= REG_RESET;
      data_oe_o <= 1'b0;
    end else if (rd_start) begin
      data_o <= status;
      data_oe_o <= 1'b1;
    end else if (first) begin
      data_o <= CALL_OPCODE;
      data_oe_o <= !ptr_mode && !slave_here;
    end else if (second) begin
      data_o <= ptr_mode ? ptr_vec : vec_low;
      data_oe_o <= owner;
    end else if (third) begin
      data_o <= icw2_q;
      data_oe_o <= owner_q;
    end else if (ack_rise || rd_end) begin
      data_oe_o <= 1'b0;
    end
  end

  // Cascade lines: master names the slave for the whole sequence
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cascade_id_o <= CASCADE_IDLE;
      cascade_id_oe_o <= 1'b0;
    end else begin
      cascade_id_oe_o <= master_q;
      if (first && via_slave) begin
        cascade_id_o <= live_level;
      end else if (final_rise || first) begin
        cascade_id_o <= CASCADE_IDLE;
      end
    end
  end

  // Interrupt output held off until initialization completes
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (init_q == INIT_READY) && res_raise;
    end
  end

endmodule
`default_nettype wire

// ===== dv/pic_core_chk.sv
// Port checker for the priority interrupt core.
// Assumes one clock domain; bound to every core instance below.
`timescale 1ns/1ps
`default_nettype none
module pic_core_chk (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic irq_ack_n_i,
  input wire logic slave_prog_buf_enable_i,
  input wire logic [7:0] data_o,
  input wire logic data_oe_o,
  input wire logic cascade_id_oe_o,
  input wire logic irq_o
);
  logic [3:0] idle_q;
  logic [3:0] boot_q;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Cycles since the last selected read or acknowledge
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      idle_q <= 4'hF;
    end else if (!irq_ack_n_i || (!rd_n_i && !cs_n_i)) begin
      idle_q <= 4'h0;
    end else if (idle_q != 4'hF) begin
      idle_q <= idle_q + 4'h1;
    end
  end
  // Init needs two host writes, so no interrupt can be due this early
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      boot_q <= 4'h0;
    end else if (boot_q != 4'hF) begin
      boot_q <= boot_q + 4'h1;
    end
  end
  sequence sel_read_s;
    $fell(rd_n_i) && !cs_n_i ##1 (!rd_n_i && !cs_n_i)[*4];
  endsequence
  sequence vec_hold_s;
    data_oe_o && !irq_ack_n_i;
  endsequence
  chk_read_drives_bus:
    assert property (sel_read_s |-> ##[0:1] data_oe_o)
    else $error("selected read left the data bus undriven");
  chk_bus_quiet:
    assert property (idle_q >= 4'h6 |-> !data_oe_o)
    else $error("data bus driven with no selected read or acknowledge");
  chk_oe_stands:
    assert property (data_oe_o && (!irq_ack_n_i || (!rd_n_i && !cs_n_i)) |=> data_oe_o)
    else $error("data drive dropped while strobe still low");
  chk_vector_stable:
    assert property (vec_hold_s ##1 vec_hold_s |-> $stable(data_o))
    else $error("vector byte changed within one acknowledge pulse");
  chk_ack_release:
    assert property ($rose(irq_ack_n_i) && rd_n_i |-> ##[1:5] !data_oe_o)
    else $error("data bus not released after acknowledge");
  chk_read_release:
    assert property ($rose(rd_n_i) && irq_ack_n_i |-> ##[1:5] !data_oe_o)
    else $error("data bus not released after read");
  // Strap passes two flops before it reaches the direction output
  chk_cascade_dir:
    assert property (1'b1 |=> cascade_id_oe_o == $past(slave_prog_buf_enable_i, 2))
    else $error("cascade direction does not follow master strap");
  chk_irq_boot:
    assert property (boot_q < 4'h8 |-> !irq_o)
    else $error("interrupt raised before initialization");
endmodule
bind priority_interrupt_core pic_core_chk u_chk (.clk_sys_i, .rst_i, .cs_n_i, .rd_n_i,
  .irq_ack_n_i, .slave_prog_buf_enable_i, .data_o, .data_oe_o, .cascade_id_oe_o, .irq_o);
`default_nettype wire

// ===== dv/pic_host_model.sv
// Host processor model: select, strobes, port select, write data, acknowledge.
// Assumes the testbench calls strobe; every pin changes at a falling edge.
`timescale 1ns/1ps
`default_nettype none
module pic_host_model (
  input wire logic clk_i,
  input wire logic [7:0] data_i,
  input wire logic data_oe_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic ps_o,
  output logic [7:0] data_o,
  output logic ack_n_o
);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    ack_n_o = 1'b1;
    ps_o = 1'b0;
    data_o = 8'h00;
  end
  // Six cycles low, six high: the core needs three of each after its synchroniser
  task automatic strobe(input logic sel, input logic rd, input logic ack, input logic ps,
      input logic [7:0] wd, output logic [7:0] d, output logic oe);
    @(negedge clk_i);
    ps_o = ps;
    data_o = wd;
    cs_n_o = !sel;
    rd_n_o = !rd;
    wr_n_o = rd || ack;
    ack_n_o = !ack;
    repeat (5) @(negedge clk_i);
    d = data_i;
    oe = data_oe_i;
    @(negedge clk_i);
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    ack_n_o = 1'b1;
    // A released bus must not keep showing the last byte
    data_o = ~wd;
    repeat (5) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== dv/priority_interrupt_core_test.sv
// Self-checking bench for the priority interrupt core.
// Assumes the host model drives the bus and the bound checker watches ports.
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_core_test;
  import pic_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] request_in = 8'h00;
  logic strap = 1'b1;
  wire cs_n;
  wire rd_n;
  wire wr_n;
  wire ps;
  wire ack_n;
  wire [7:0] host_d;
  logic [7:0] dout;
  logic doe;
  logic [2:0] cas;
  logic cas_oe;
  logic irq;
  logic [7:0] rv;
  logic ro;
  int bad_count = 0;
  int num_checks = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  priority_interrupt_core DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .request_in_i(request_in),
    .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .port_select_i(ps), .irq_ack_n_i(ack_n),
    .slave_prog_buf_enable_i(strap), .data_i(host_d), .data_o(dout), .data_oe_o(doe),
    .cascade_id_i(3'h0), .cascade_id_o(cas), .cascade_id_oe_o(cas_oe), .irq_o(irq));
  pic_host_model host (.clk_i(clk_sys_i), .data_i(dout), .data_oe_i(doe), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .ps_o(ps), .data_o(host_d), .ack_n_o(ack_n));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic p, input logic [7:0] d);
    host.strobe(1'b1, 1'b0, 1'b0, p, d, rv, ro);
  endtask
  task automatic rd(input logic p);
    host.strobe(1'b1, 1'b1, 1'b0, p, 8'h00, rv, ro);
  endtask
  task automatic ack();
    host.strobe(1'b0, 1'b0, 1'b1, 1'b0, 8'h00, rv, ro);
  endtask
  // Status read through a read-register command, then a read at port 0
  task automatic rd_reg(input logic ris);
    wr(1'b0, {7'h05, ris});
    rd(1'b0);
  endtask
  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (irq !== exp && n < 20) begin
      @(negedge clk_sys_i);
      n++;
    end
    check({7'h00, irq}, {7'h00, exp});
    if (irq !== exp) begin
      finish_test();
    end
  endtask
  task automatic t_strap();
    repeat (3) @(negedge clk_sys_i);
    check({7'h00, cas_oe}, 8'h01);
    strap = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    check({7'h00, cas_oe}, 8'h00);
    strap = 1'b1;
  endtask
  // Call mode, single core, interval four, no auto end, then masking
  task automatic t_call();
    wr(1'b0, 8'hB6);
    wr(1'b1, 8'h12);
    request_in = 8'h28;
    wait_irq(1'b1);
    ack();
    check(rv, CALL_OPCODE);
    ack();
    check(rv, 8'hAC);
    ack();
    check(rv, 8'h12);
    check({7'h00, ro}, 8'h01);
    rd_reg(1'b1);
    check(rv, 8'h08);
    rd_reg(1'b0);
    check(rv, 8'h20);
    wait_irq(1'b0);
    wr(1'b0, 8'h20);
    wait_irq(1'b1);
    wr(1'b1, 8'h20);
    wait_irq(1'b0);
    rd(1'b1);
    check(rv, 8'h20);
    wr(1'b1, 8'h01);
    wait_irq(1'b1);
    host.strobe(1'b0, 1'b0, 1'b0, 1'b1, 8'hFF, rv, ro);
    host.strobe(1'b0, 1'b1, 1'b0, 1'b1, 8'h00, rv, ro);
    check({7'h00, ro}, 8'h00);
    rd(1'b1);
    check(rv, 8'h01);
    wr(1'b0, 8'h0C);
    rd(1'b0);
    check(rv, 8'h85);
    wait_irq(1'b0);
    request_in = 8'h00;
  endtask
  // Cascade master, call mode: slaves on levels 2 and 7
  task automatic t_cascade();
    wr(1'b0, 8'h14);
    wr(1'b1, 8'h30);
    wr(1'b1, 8'h84);
    request_in = 8'h04;
    wait_irq(1'b1);
    ack();
    check(rv, CALL_OPCODE);
    check({5'h00, cas}, 8'h02);
    ack();
    check({7'h00, ro}, 8'h00);
    ack();
    check({7'h00, ro}, 8'h00);
    check({5'h00, cas}, {5'h00, CASCADE_IDLE});
    request_in = 8'h00;
    wr(1'b0, 8'h20);
    ack();
    check({5'h00, cas}, {5'h00, CASCADE_IDLE});
    ack();
    check(rv, 8'h1C);
    check({7'h00, ro}, 8'h01);
    ack();
    check(rv, 8'h30);
  endtask
  // Pointer mode with auto end, then an acknowledge with nothing pending
  task automatic t_pointer();
    wr(1'b0, 8'h13);
    wr(1'b1, 8'hA8);
    wr(1'b1, 8'h03);
    rd(1'b1);
    check(rv, REG_RESET);
    request_in = 8'h40;
    wait_irq(1'b1);
    ack();
    check({7'h00, ro}, 8'h00);
    ack();
    check(rv, 8'hAE);
    rd_reg(1'b0);
    check(rv, 8'h00);
    rd_reg(1'b1);
    check(rv, 8'h00);
    ack();
    ack();
    check(rv, 8'hAF);
    check({5'h00, cas}, {5'h00, CASCADE_IDLE});
    request_in = 8'h00;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    t_strap();
    t_call();
    t_pointer();
    t_cascade();
    finish_test();
  end
endmodule
`default_nettype wire
